// *** logic/nvdsbw_byte_write.sv ***
module nvdsbw_byte_write #(
    parameter int                           SIZE        = nvdsbw_pkg::STORE_SIZE,
    parameter logic [nvdsbw_pkg::CNT_W-1:0] MAINT_TICKS =
        nvdsbw_pkg::CNT_W'(nvdsbw_pkg::MAINT_CYCLES)
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       push_valid,
    input  wire logic [7:0] push_byte,
    input  wire logic       pop_valid,
    input  wire logic       call_valid,
    input  wire logic       flash_fault_flag,
    input  wire logic [7:0] flash_bit_fault,
    output logic            busy,
    output logic            done,
    output logic [7:0]      first_working_register,
    output logic [1:0]      operand_depth,
    output logic [7:0]      stack_reserve
);
    // slot index width; sizes above 256 words cannot be named by one address byte
    localparam int AW = $clog2(SIZE);

    localparam logic [nvdsbw_pkg::CNT_W-1:0] NORMAL_TICKS =
        nvdsbw_pkg::CNT_W'(nvdsbw_pkg::NORMAL_CYCLES);
    localparam logic [nvdsbw_pkg::CNT_W-1:0] ILLEGAL_TICKS =
        nvdsbw_pkg::CNT_W'(nvdsbw_pkg::ILLEGAL_CYCLES);
    localparam logic [nvdsbw_pkg::WCNT_W-1:0] MAINT_LAST =
        nvdsbw_pkg::WCNT_W'(nvdsbw_pkg::MAINT_PERIOD - 1);
    localparam logic [nvdsbw_pkg::CNT_W-1:0] TICK_ONE =
        nvdsbw_pkg::CNT_W'(1);
    localparam logic [nvdsbw_pkg::WCNT_W-1:0] WCNT_ONE =
        nvdsbw_pkg::WCNT_W'(1);
    localparam logic [7:0] RESERVE_BYTES =
        8'(nvdsbw_pkg::STACK_EXTRA_BYTES);

    nvdsbw_pkg::nvdsbw_state_type  state_ff;
    nvdsbw_pkg::nvdsbw_state_type  nxt_state;
    logic [1:0]                    depth_ff;
    logic [7:0]                    target_ff;
    logic [7:0]                    value_ff;
    logic [nvdsbw_pkg::CNT_W-1:0]  tmr_ff;
    logic [nvdsbw_pkg::WCNT_W-1:0] wcnt_ff;
    logic                          fault_seen_ff;
    logic [7:0]                    status_ff;
    logic [7:0]                    nxt_status;
    logic [7:0]                    reserve_ff;
    logic [7:0]                    store_ff [SIZE];
    logic                          take_push;
    logic                          take_pop;
    logic                          take_call;
    logic                          call_legal;
    logic                          tmr_last;
    logic                          maint_due;
    logic                          in_idle;
    logic [AW-1:0]                 slot;

    // address decode, used for the start decision and again as a guard on the store
    function automatic logic is_legal(input logic [7:0] addr);
        return int'(addr) < SIZE;
    endfunction : is_legal

    assign in_idle    = (state_ff == nvdsbw_pkg::NVDSBW_IDLE);
    // a call wins over a push or pop offered in the same cycle
    assign take_call  = in_idle && call_valid && (depth_ff == 2'h2);
    assign take_push  = in_idle && !call_valid && push_valid && (depth_ff != 2'h2);
    assign take_pop   = in_idle && !call_valid && !push_valid && pop_valid
                        && (depth_ff != 2'h0);
    assign call_legal = is_legal(target_ff);
    assign tmr_last   = (tmr_ff == TICK_ONE);
    assign maint_due  = (wcnt_ff == MAINT_LAST);
    assign slot       = target_ff[AW-1:0];

    assign busy                   = !in_idle;
    assign done                   = (state_ff == nvdsbw_pkg::NVDSBW_DONE);
    assign first_working_register = status_ff;
    assign operand_depth          = depth_ff;
    assign stack_reserve          = reserve_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            nvdsbw_pkg::NVDSBW_IDLE: begin
                if (take_call) begin
                    if (call_legal) begin
                        nxt_state = nvdsbw_pkg::NVDSBW_PROGRAM;
                    end else begin
                        nxt_state = nvdsbw_pkg::NVDSBW_WAIT;
                    end
                end
            end
            nvdsbw_pkg::NVDSBW_WAIT: begin
                if (tmr_last) begin
                    nxt_state = nvdsbw_pkg::NVDSBW_DONE;
                end
            end
            nvdsbw_pkg::NVDSBW_PROGRAM: begin
                if (tmr_last) begin
                    nxt_state = nvdsbw_pkg::NVDSBW_VERIFY;
                end
            end
            nvdsbw_pkg::NVDSBW_VERIFY: begin
                nxt_state = nvdsbw_pkg::NVDSBW_DONE;
            end
            nvdsbw_pkg::NVDSBW_DONE: begin
                nxt_state = nvdsbw_pkg::NVDSBW_IDLE;
            end
            default: begin
                nxt_state = nvdsbw_pkg::NVDSBW_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= nvdsbw_pkg::NVDSBW_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // operand stack: the operands stay until the requester pops them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            depth_ff <= nvdsbw_pkg::DEPTH_RESET;
        end else if (take_push) begin
            depth_ff <= depth_ff + 2'h1;
        end else if (take_pop) begin
            depth_ff <= depth_ff - 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            target_ff <= 8'h00;
        end else if (take_push && (depth_ff == 2'h0)) begin
            target_ff <= push_byte;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_ff <= 8'h00;
        end else if (take_push && (depth_ff == 2'h1)) begin
            value_ff <= push_byte;
        end
    end

    // fixed cycle counts, so every duration stretches as mclk slows down
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tmr_ff <= '0;
        end else if (take_call) begin
            if (!call_legal) begin
                tmr_ff <= ILLEGAL_TICKS;
            end else if (maint_due) begin
                tmr_ff <= NORMAL_TICKS + MAINT_TICKS;
            end else begin
                tmr_ff <= NORMAL_TICKS;
            end
        end else if (tmr_ff != '0) begin
            tmr_ff <= tmr_ff - TICK_ONE;
        end
    end

    // only legal writes wear the array, so only they advance the maintenance count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt_ff <= '0;
        end else if (take_call && call_legal) begin
            if (maint_due) begin
                wcnt_ff <= '0;
            end else begin
                wcnt_ff <= wcnt_ff + WCNT_ONE;
            end
        end
    end

    // set and clear never meet: clear only in idle, set only while writing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_seen_ff <= 1'b0;
        end else if (take_call) begin
            fault_seen_ff <= 1'b0;
        end else if ((state_ff == nvdsbw_pkg::NVDSBW_PROGRAM) && flash_fault_flag) begin
            fault_seen_ff <= 1'b1;
        end
    end

    // nonvolatile in silicon; reset here only stands for an erased array
    for (genvar i = 0; i < SIZE; i++) begin : g_word
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                store_ff[i] <= nvdsbw_pkg::ERASED_BYTE;
            end else if ((state_ff == nvdsbw_pkg::NVDSBW_PROGRAM) && tmr_last
                         && is_legal(target_ff) && (slot == AW'(i))) begin
                // flash_bit_fault stands for cells that fail to take the new value
                store_ff[i] <= value_ff ^ flash_bit_fault;
            end
        end
    end

    always_comb begin
        nxt_status = status_ff;
        if (state_ff == nvdsbw_pkg::NVDSBW_VERIFY) begin
            nxt_status = nvdsbw_pkg::STATUS_RESET;
            nxt_status[nvdsbw_pkg::STAT_FLASH_ERR] = fault_seen_ff | flash_fault_flag;
            nxt_status[nvdsbw_pkg::STAT_WRITE_ERR] = (store_ff[slot] != value_ff);
        end else if ((state_ff == nvdsbw_pkg::NVDSBW_WAIT) && tmr_last) begin
            nxt_status = nvdsbw_pkg::STATUS_RESET;
            nxt_status[nvdsbw_pkg::STAT_BAD_ADDR] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= nvdsbw_pkg::STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reserve_ff <= 8'h00;
        end else if (take_call) begin
            reserve_ff <= RESERVE_BYTES;
        end else if (state_ff == nvdsbw_pkg::NVDSBW_DONE) begin
            reserve_ff <= 8'h00;
        end
    end
endmodule : nvdsbw_byte_write

// *** shared/nvdsbw_pkg.sv ***
package nvdsbw_pkg;
    // timing is specified in cycles of a reference clock, so it scales with mclk
    localparam int REF_CLK_KHZ       = 20000;
    localparam int NORMAL_TIME_NS    = 136000;
    localparam int ILLEGAL_TIME_NS   = 7000;
    localparam int MAINT_TIME_US     = 58000;
    // scale by MHz first: ns times kHz would overflow a 32-bit int
    localparam int NORMAL_CYCLES     = (NORMAL_TIME_NS * (REF_CLK_KHZ / 1000)) / 1000;
    localparam int ILLEGAL_CYCLES    = (ILLEGAL_TIME_NS * (REF_CLK_KHZ / 1000)) / 1000;
    localparam int MAINT_CYCLES      = (MAINT_TIME_US * REF_CLK_KHZ) / 1000;
    localparam int CNT_W             = 21;
    localparam int MAINT_PERIOD      = 200;
    localparam int WCNT_W            = 8;
    localparam int STACK_EXTRA_BYTES = 16;
    localparam int STORE_SIZE        = 64;

    localparam int STAT_WRITE_ERR = 0;
    localparam int STAT_BAD_ADDR  = 1;
    localparam int STAT_FLASH_ERR = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] DEPTH_RESET  = 2'h0;
    localparam logic [7:0] ERASED_BYTE  = 8'hff;

    typedef enum logic [4:0] {
        NVDSBW_IDLE    = 5'b00001,
        NVDSBW_WAIT    = 5'b00010,
        NVDSBW_PROGRAM = 5'b00100,
        NVDSBW_VERIFY  = 5'b01000,
        NVDSBW_DONE    = 5'b10000
    } nvdsbw_state_type;
endpackage : nvdsbw_pkg

// *** logic/nvdsbw_fix_notice.sv ***
// intentionally empty

// *** tb/nvdsbw_props.sv ***
module nvdsbw_props (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       call_valid,
    input wire logic       busy,
    input wire logic       done,
    input wire logic [7:0] first_working_register,
    input wire logic [1:0] operand_depth,
    input wire logic [7:0] stack_reserve
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_rsvd_bits_zero: assert property (first_working_register[7:3] == 5'h00)
        else $error("reserved status bits set");
    chk_done_one_pulse: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    chk_status_on_done: assert property (!$rose(done) |-> $stable(first_working_register))
        else $error("status changed outside completion");
    chk_call_starts: assert property ((call_valid && !busy && operand_depth == 2'h2) |=> busy)
        else $error("call with two operands not started");
    chk_reserve_busy: assert property (busy |-> stack_reserve == 8'(nvdsbw_pkg::STACK_EXTRA_BYTES))
        else $error("stack reserve missing while busy");
    chk_reserve_idle: assert property (!busy |-> stack_reserve == 8'h00)
        else $error("stack reserve held while idle");
    chk_depth_range: assert property (operand_depth <= 2'h2)
        else $error("operand depth beyond two");
endmodule : nvdsbw_props

// *** tb/nvdsbw_req.sv ***
module nvdsbw_req (input wire logic mclk, output logic push_valid, call_valid, pop_valid,
                   output logic [7:0] push_byte);
    timeunit 1ns; timeprecision 1ps;
    initial {push_valid, call_valid, pop_valid, push_byte} = 11'h000;
    task automatic pop(); // both operands come off again
        @(negedge mclk) pop_valid = 1'b1;
        repeat (2) @(negedge mclk);
        pop_valid = 1'b0;
    endtask : pop
    task automatic req(input logic [7:0] a, d);
        @(negedge mclk) {push_valid, push_byte} = {1'b1, a}; // address goes first
        @(negedge mclk) push_byte = d;
        @(negedge mclk) {push_valid, call_valid} = 2'h1;
        @(negedge mclk) call_valid = 1'b0;
    endtask : req
endmodule : nvdsbw_req

// *** tb/tb_top.sv ***
module tb_top;
    timeunit 1ns; timeprecision 1ps;
    logic mclk = 0, rst_n = 0, ff = 0, pv, cv, po, busy, done;
    logic [7:0] pb, st, sr, bf = 8'h00;
    logic [1:0] dp;
    int n_errors = 0, check_count = 0;
    always #4 mclk = ~mclk;
    nvdsbw_req i_req (.mclk, .push_valid(pv), .call_valid(cv), .pop_valid(po), .push_byte(pb));
    nvdsbw_byte_write #(.MAINT_TICKS(21'h64)) i_dut (.mclk, .rst_n, .push_valid(pv),
        .push_byte(pb), .pop_valid(po), .call_valid(cv), .flash_fault_flag(ff),
        .flash_bit_fault(bf), .busy, .done, .first_working_register(st),
        .operand_depth(dp), .stack_reserve(sr));
    task automatic wr(input logic [7:0] a, input logic [7:0] e, input int ticks);
        int t;
        i_req.req(a, 8'h5a);
        for (t = 0; t < 4000 && done !== 1'b1; t++) @(negedge mclk);
        check_count += 4;
        if (st !== e) begin
            n_errors++; $display("BAD status exp %h got %h", e, st);
        end
        if (t < ticks || t > ticks + 1) begin
            n_errors++; $display("BAD cycles exp %0d got %0d", ticks, t);
        end
        if (sr !== 8'(nvdsbw_pkg::STACK_EXTRA_BYTES)) begin
            n_errors++; $display("BAD reserve exp %h got %h", 8'h10, sr);
        end
        i_req.pop();
        if (dp !== 2'h0) begin
            n_errors++; $display("BAD depth exp 0 got %h", dp);
        end
        $display("test end addr %h", a);
    endtask : wr
    task give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // four writes need about 8300 cycles; this leaves ample margin
    initial begin #200000 n_errors++; give_verdict(); end
    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1;
        wr(8'h03, 8'h00, nvdsbw_pkg::NORMAL_CYCLES);
        wr(8'h40, 8'h02, nvdsbw_pkg::ILLEGAL_CYCLES);
        ff = 1; wr(8'h04, 8'h04, nvdsbw_pkg::NORMAL_CYCLES);
        ff = 0; bf = 8'h01; wr(8'h05, 8'h01, nvdsbw_pkg::NORMAL_CYCLES);
        give_verdict();
    end
endmodule : tb_top
bind nvdsbw_byte_write nvdsbw_props i_props (.mclk, .rst_n, .call_valid, .busy, .done,
    .first_working_register, .operand_depth, .stack_reserve);
